// file: verilog/sfseq_pkg.sv
// Package of register map, field positions and timing counts for the sequencer.
package sfseq_pkg;
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned SOFTSTART_MS = 10;
	localparam int unsigned FAULT_MS = 48;
	localparam int unsigned RECOVERY_MS = 420;
	localparam int unsigned BROWNOUT_MS = 50;
	localparam int unsigned JITTER_HZ = 300;
	localparam int unsigned SOFTSTART_CYC = CLK_HZ / 1000 * SOFTSTART_MS;
	localparam int unsigned FAULT_CYC = CLK_HZ / 1000 * FAULT_MS;
	localparam int unsigned RECOVERY_CYC = CLK_HZ / 1000 * RECOVERY_MS;
	localparam int unsigned BROWNOUT_CYC = CLK_HZ / 1000 * BROWNOUT_MS;
	localparam int unsigned JITTER_CYC = CLK_HZ / JITTER_HZ;
	localparam logic [11:0] ADDR_STATUS = 12'h000;
	localparam logic [11:0] ADDR_MASK = 12'h004;
	localparam logic [11:0] ADDR_STATE = 12'h008;
	localparam logic [11:0] ADDR_CTRL = 12'h00C;
	localparam int unsigned EV_FAULT = 0;
	localparam int unsigned EV_OVP = 1;
	localparam int unsigned EV_BROWNOUT = 2;
	localparam int unsigned EV_LINE_OVP = 3;
	localparam int unsigned EV_LINE_INHIBIT = 4;
	localparam int unsigned EV_W = 5;
	localparam logic [4:0] MASK_RESET = 5'h00;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	typedef enum logic [2:0] {
		SFSEQ_OFF, SFSEQ_SOFT, SFSEQ_RUN, SFSEQ_RECOVER
	} sfseq_state_t;
endpackage

// file: verilog/sfseq_top.sv
// Protection and start-up sequencer that gates power switch drive pulses.
`timescale 1ns/100ps
// Overview of operation
// - Reduced start current below 1.6 V supply.
// - Enable pulses once supply reaches turn-on level.
// - Ramp peak set-point over 10 ms.
// - Low feedback current raises fault flag.
// - Fault persisting 48 ms stops pulses 420 ms.
// - Retry as soon as each recovery ends.
// - Supply overvoltage stops pulses one recovery.
// - Soft-start on every switching start.
// - Sawtooth jitter repeats at 300 Hz.
// - Jitter always on, no disable.
// - Grounded line pin: inhibit on low drain.
// - Line pin level selects brown-out or detection.
// - Brown-out off for 50 ms stops pulsing.
// - Line overvoltage stops pulses until released.
// - Brown-out ignored during soft-start.
module sfseq_top
	import sfseq_pkg::*;
#(
	parameter int unsigned SOFT_CYC = SOFTSTART_CYC,
	parameter int unsigned FLT_CYC = FAULT_CYC,
	parameter int unsigned REC_CYC = RECOVERY_CYC,
	parameter int unsigned BO_CYC = BROWNOUT_CYC,
	parameter int unsigned JIT_CYC = JITTER_CYC,
	parameter int unsigned RAMP_W = 8
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic supply_above_start_level,
	input wire logic supply_turn_on_level,
	input wire logic supply_overvolt,
	input wire logic feedback_fault_level,
	input wire logic brownout_enable_level,
	input wire logic brownout_on_level,
	input wire logic brownout_off_level,
	input wire logic line_overvolt_on_level,
	input wire logic line_overvolt_off_level,
	input wire logic drain_enable_level,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic startup_current_reduced,
	output logic startup_current_nominal,
	output logic drive_enable,
	output logic max_current_fault_flag,
	output logic [RAMP_W-1:0] peak_setpoint,
	output logic [RAMP_W-1:0] jitter_ramp,
	output logic irq
);
	// A short soft-start still needs at least one cycle per ramp step.
	localparam logic [31:0] SOFT_STEP = (SOFT_CYC >> RAMP_W) == 0 ?
		32'h0000_0001 : 32'(SOFT_CYC >> RAMP_W);
	localparam logic [RAMP_W-1:0] RAMP_MAX = '1;

	sfseq_state_t state_r;
	logic [31:0] soft_cnt_r;
	logic [31:0] flt_cnt_r;
	logic [31:0] rec_cnt_r;
	logic [31:0] bo_cnt_r;
	logic [31:0] jit_cnt_r;
	logic [31:0] step_cnt_r;
	logic bo_armed_r;
	logic bo_stop_r;
	logic line_ovp_r;
	logic line_inhibit_r;
	logic check_drain_r;
	logic [EV_W-1:0] status_r;
	logic [EV_W-1:0] mask_r;
	logic [EV_W-1:0] ev;
	logic brownout_mode;
	logic gate_off;
	logic fault_trip;
	logic ovp_trip;
	logic wr_acc;

	assign brownout_mode = brownout_enable_level;
	assign fault_trip = state_r == SFSEQ_RUN || state_r == SFSEQ_SOFT
		? (feedback_fault_level && flt_cnt_r >= FLT_CYC - 1) : 1'b0;
	assign ovp_trip = supply_overvolt &&
		(state_r == SFSEQ_SOFT || state_r == SFSEQ_RUN);
	// Any single condition is enough to hold the switch off.
	assign gate_off = line_ovp_r || bo_stop_r || line_inhibit_r ||
		!supply_turn_on_level;
	assign wr_acc = psel && penable && pwrite;

	// Start-up current level follows the 1.6 V comparator.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			startup_current_reduced <= 1'b1;
			startup_current_nominal <= 1'b0;
		end
		else
		begin
			startup_current_reduced <= !supply_above_start_level;
			startup_current_nominal <= supply_above_start_level;
		end
	end

	// Main sequence; recovery timer is shared by fault and overvoltage.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r <= SFSEQ_OFF;
			rec_cnt_r <= 32'h0000_0000;
			soft_cnt_r <= 32'h0000_0000;
			check_drain_r <= 1'b1;
		end
		else
		begin
			unique case (state_r)
				SFSEQ_OFF:
				begin
					check_drain_r <= 1'b1;
					if (supply_turn_on_level && !gate_off)
					begin
						state_r <= SFSEQ_SOFT;
						soft_cnt_r <= 32'h0000_0000;
					end
				end
				SFSEQ_SOFT, SFSEQ_RUN:
				begin
					if (state_r == SFSEQ_SOFT)
					begin
						soft_cnt_r <= soft_cnt_r + 32'h0000_0001;
						if (soft_cnt_r >= SOFT_CYC - 1)
							state_r <= SFSEQ_RUN;
					end
					if (fault_trip || ovp_trip)
					begin
						state_r <= SFSEQ_RECOVER;
						rec_cnt_r <= 32'h0000_0000;
					end
					else if (gate_off)
						state_r <= SFSEQ_OFF;
					else
						check_drain_r <= 1'b0;
				end
				SFSEQ_RECOVER:
				begin
					check_drain_r <= 1'b1;
					rec_cnt_r <= rec_cnt_r + 32'h0000_0001;
					if (rec_cnt_r >= REC_CYC - 1)
						state_r <= SFSEQ_OFF;
				end
				default:
					state_r <= SFSEQ_OFF;
			endcase
		end
	end

	// Fault timer runs while the flag stays up; restarts each attempt.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			flt_cnt_r <= 32'h0000_0000;
			max_current_fault_flag <= 1'b0;
		end
		else
		begin
			max_current_fault_flag <= feedback_fault_level;
			if (!feedback_fault_level || state_r == SFSEQ_RECOVER ||
				state_r == SFSEQ_OFF)
				flt_cnt_r <= 32'h0000_0000;
			else if (flt_cnt_r < FLT_CYC - 1)
				flt_cnt_r <= flt_cnt_r + 32'h0000_0001;
		end
	end

	// Brown-out stays blind in soft-start, then a 50 ms grace period.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			bo_cnt_r <= 32'h0000_0000;
			bo_stop_r <= 1'b1;
			bo_armed_r <= 1'b0;
		end
		else if (!brownout_mode)
		begin
			bo_cnt_r <= 32'h0000_0000;
			bo_stop_r <= 1'b0;
			bo_armed_r <= 1'b0;
		end
		else if (bo_stop_r)
		begin
			bo_cnt_r <= 32'h0000_0000;
			if (brownout_on_level)
				bo_stop_r <= 1'b0;
		end
		else if (state_r == SFSEQ_SOFT)
			bo_cnt_r <= 32'h0000_0000;
		else if (!brownout_off_level)
		begin
			bo_armed_r <= 1'b1;
			bo_cnt_r <= bo_cnt_r + 32'h0000_0001;
			if (bo_cnt_r >= BO_CYC - 1)
				bo_stop_r <= 1'b1;
		end
		else
		begin
			bo_armed_r <= 1'b0;
			bo_cnt_r <= 32'h0000_0000;
		end
	end

	// Line overvoltage with hysteresis, and drain check when grounded.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			line_ovp_r <= 1'b0;
			line_inhibit_r <= 1'b0;
		end
		else
		begin
			if (line_overvolt_on_level)
				line_ovp_r <= 1'b1;
			else if (!line_overvolt_off_level)
				line_ovp_r <= 1'b0;
			line_inhibit_r <= !brownout_mode && check_drain_r &&
				!drain_enable_level;
		end
	end

	// Soft-start ramp of peak set-point, full scale in run, zero when off or recovering.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			peak_setpoint <= '0;
			step_cnt_r <= 32'h0000_0000;
		end
		else if (state_r != SFSEQ_SOFT)
		begin
			step_cnt_r <= 32'h0000_0000;
			peak_setpoint <= state_r == SFSEQ_RUN ? RAMP_MAX : '0;
		end
		else if (step_cnt_r >= SOFT_STEP - 32'h0000_0001)
		begin
			step_cnt_r <= 32'h0000_0000;
			if (peak_setpoint != RAMP_MAX)
				peak_setpoint <= peak_setpoint + 1'b1;
		end
		else
			step_cnt_r <= step_cnt_r + 32'h0000_0001;
	end

	// Free-running jitter sawtooth; there is no control to stop it.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			jit_cnt_r <= 32'h0000_0000;
		else if (jit_cnt_r >= JIT_CYC - 1)
			jit_cnt_r <= 32'h0000_0000;
		else
			jit_cnt_r <= jit_cnt_r + 32'h0000_0001;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			jitter_ramp <= '0;
		else
			jitter_ramp <= RAMP_W'((64'(jit_cnt_r) << RAMP_W) / JIT_CYC);
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			drive_enable <= 1'b0;
		else
			drive_enable <= (state_r == SFSEQ_SOFT || state_r == SFSEQ_RUN)
				&& !gate_off && !fault_trip && !ovp_trip;
	end

	// Event sources for sticky status; set wins over a write-one clear.
	always_comb
	begin
		ev = '0;
		ev[EV_FAULT] = fault_trip;
		ev[EV_OVP] = ovp_trip;
		ev[EV_BROWNOUT] = bo_armed_r && bo_cnt_r >= BO_CYC - 1;
		ev[EV_LINE_OVP] = line_overvolt_on_level && !line_ovp_r;
		ev[EV_LINE_INHIBIT] = !brownout_mode && check_drain_r &&
			!drain_enable_level && !line_inhibit_r;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			status_r <= '0;
			mask_r <= MASK_RESET;
			irq <= 1'b0;
		end
		else
		begin
			if (wr_acc && paddr == ADDR_STATUS)
				status_r <= (status_r & ~pwdata[EV_W-1:0]) | ev;
			else
				status_r <= status_r | ev;
			if (wr_acc && paddr == ADDR_MASK)
				mask_r <= pwdata[EV_W-1:0];
			irq <= |(status_r & mask_r);
		end
	end

	// Zero-wait APB slave; unmapped addresses return error.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && !penable)
			begin
				unique case (paddr)
					ADDR_STATUS: prdata <= 32'(status_r);
					ADDR_MASK: prdata <= 32'(mask_r);
					ADDR_STATE: prdata <= {24'h00_0000, bo_stop_r,
						line_ovp_r, line_inhibit_r,
						max_current_fault_flag, drive_enable,
						3'(state_r)};
					ADDR_CTRL: prdata <= CTRL_RESET;
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule

// file: verification/sfseq_properties.sv
// Concurrent checks on the drive gating, fault flag and jitter ramp of the switcher fault sequencer.
`timescale 1ns/100ps
module sfseq_properties
#(
	parameter int unsigned FLT_CYC = 20,
	parameter int unsigned JIT_CYC = 16
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic supply_overvolt,
	input wire logic feedback_fault_level,
	input wire logic brownout_enable_level,
	input wire logic line_overvolt_on_level,
	input wire logic drain_enable_level,
	input wire logic drive_enable,
	input wire logic max_current_fault_flag,
	input wire logic [7:0] peak_setpoint,
	input wire logic [7:0] jitter_ramp
);
	int unsigned on_cnt;
	// Counts pulses allowed under a standing fault; the timer must end this.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			on_cnt <= 0;
		else if (drive_enable && max_current_fault_flag)
			on_cnt <= on_cnt + 1;
		else
			on_cnt <= 0;
	end
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!resetn);
	a_fault_flag: assert property (1 |=>
		max_current_fault_flag == $past(feedback_fault_level))
		else $error("fault flag does not follow feedback");
	a_fault_limit: assert property (on_cnt <= FLT_CYC + 4)
		else $error("pulses outlive fault timer");
	a_recover_hold: assert property ($fell(drive_enable) &&
		max_current_fault_flag |-> !drive_enable [*8])
		else $error("recovery wait cut short");
	a_ovp_stop: assert property ($rose(supply_overvolt) |->
		##[1:3] !drive_enable)
		else $error("supply overvoltage did not stop pulses");
	a_line_ovp: assert property (line_overvolt_on_level [*3] |->
		!drive_enable)
		else $error("pulses during line overvoltage");
	a_soft_ramp: assert property ($rose(drive_enable) |->
		peak_setpoint != 8'hFF)
		else $error("switching began without soft-start");
	a_drain_hold: assert property (!brownout_enable_level &&
		!drain_enable_level && !drive_enable |=> !drive_enable)
		else $error("pulses with low drain voltage");
	a_jitter_moves: assert property (1 |->
		##[1:JIT_CYC] jitter_ramp != $past(jitter_ramp))
		else $error("jitter ramp stalled");
endmodule

// file: verification/sfseq_analog_model.sv
// Comparator bank standing in for the analog front end of the switcher.
`timescale 1ns/100ps
module sfseq_analog_model
#(
	parameter int BO_ON_MV = 800,
	parameter int BO_OFF_MV = 750,
	parameter int LOVP_ON_MV = 3000,
	parameter int LOVP_OFF_MV = 2800
)
(
	input int vcc_dv,
	input int line_mv,
	input int drain_v,
	input int fb_ua,
	output logic supply_above_start_level,
	output logic supply_turn_on_level,
	output logic supply_overvolt,
	output logic feedback_fault_level,
	output logic brownout_enable_level,
	output logic brownout_on_level,
	output logic brownout_off_level,
	output logic line_overvolt_on_level,
	output logic line_overvolt_off_level,
	output logic drain_enable_level
);
	assign supply_above_start_level = vcc_dv >= 16;
	assign supply_turn_on_level = vcc_dv >= 84;
	assign supply_overvolt = vcc_dv > 180;
	assign feedback_fault_level = fb_ua < 35;
	assign brownout_enable_level = line_mv > 50;
	assign brownout_on_level = line_mv > BO_ON_MV;
	assign brownout_off_level = line_mv > BO_OFF_MV;
	assign line_overvolt_on_level = line_mv > LOVP_ON_MV;
	assign line_overvolt_off_level = line_mv > LOVP_OFF_MV;
	assign drain_enable_level = drain_v > 91;
endmodule

// file: verification/tb_sfseq_top.sv
// Self-checking bench for the switcher fault sequencer.
`timescale 1ns/100ps
module tb_sfseq_top;
	import sfseq_pkg::*;
	localparam int SC = 32;
	localparam int FC = 20;
	localparam int RC = 40;
	localparam int BC = 20;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, irq, drive_enable, max_current_fault_flag;
	logic startup_current_reduced, startup_current_nominal;
	logic [7:0] peak_setpoint, jitter_ramp;
	logic supply_above_start_level, supply_turn_on_level, supply_overvolt;
	logic feedback_fault_level, brownout_enable_level, brownout_on_level;
	logic brownout_off_level, line_overvolt_on_level;
	logic line_overvolt_off_level, drain_enable_level;
	int vcc_dv = 0;
	int line_mv = 0;
	int drain_v = 200;
	int fb_ua = 50;
	int error_cnt = 0;
	int checked = 0;
	int n;
	sfseq_top #(.SOFT_CYC(SC), .FLT_CYC(FC), .REC_CYC(RC), .BO_CYC(BC),
		.JIT_CYC(16)) sfseq_top_i (.*);
	sfseq_analog_model sfseq_analog_model_i (.*);
	always #25 core_clk = ~core_clk;
	task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_b(input logic g, input logic e);
		chk_w({31'h0, g}, {31'h0, e});
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge core_clk);
	endtask
	// Bounded wait so that a stuck gate shows as a mismatch, not a hang.
	task automatic wde(input logic v, input int m);
		n = 0;
		while (drive_enable !== v && n < m)
		begin
			@(posedge core_clk);
			n++;
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rdr(input logic [11:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	task automatic t_regs;
		rdr(ADDR_CTRL);
		chk_w(rd, CTRL_RESET);
		rdr(ADDR_MASK);
		chk_w(rd, {27'h0, MASK_RESET});
		apb(1'b1, ADDR_MASK, 32'h0000_0001);
		rdr(ADDR_MASK);
		chk_w(rd, 32'h0000_0001);
		rdr(12'h010);
		chk_b(er, 1'b1);
		chk_w(rd, 32'h0000_0000);
	endtask
	task automatic t_start;
		chk_b(startup_current_reduced, 1'b1);
		vcc_dv <= 20;
		wt(3);
		chk_b(startup_current_nominal, 1'b1);
		vcc_dv <= 90;
		wde(1'b1, 40);
		chk_b(n < 8, 1'b1);
		chk_b(peak_setpoint != 8'hFF, 1'b1);
		wt(SC + 4);
		chk_w({24'h0, peak_setpoint}, 32'h0000_00FF);
	endtask
	task automatic t_fault;
		fb_ua <= 10;
		wt(3);
		chk_b(max_current_fault_flag, 1'b1);
		wde(1'b0, FC + 20);
		chk_b(n inside {[FC - 6:FC + 4]}, 1'b1);
		rdr(ADDR_STATUS);
		chk_b(rd[EV_FAULT], 1'b1);
		chk_b(irq, 1'b1);
		wde(1'b1, RC + 20);
		chk_b(n inside {[RC - 10:RC + 4]}, 1'b1);
		wde(1'b0, FC + 20);
		chk_b(n inside {[FC - 4:FC + 6]}, 1'b1);
		fb_ua <= 50;
		wde(1'b1, RC + 20);
		wt(FC * 2);
		chk_b(drive_enable, 1'b1);
		apb(1'b1, ADDR_STATUS, 32'h0000_001F);
		wt(2);
		chk_b(irq, 1'b0);
	endtask
	task automatic t_ovp;
		vcc_dv <= 190;
		wt(4);
		chk_b(drive_enable, 1'b0);
		vcc_dv <= 90;
		wde(1'b1, RC + 20);
		chk_b(n inside {[RC - 8:RC + 6]}, 1'b1);
		vcc_dv <= 190;
		drain_v <= 50;
		wt(4);
		vcc_dv <= 90;
		wde(1'b1, RC + 20);
		chk_b(drive_enable, 1'b0);
		drain_v <= 200;
		wde(1'b1, 10);
		chk_b(peak_setpoint != 8'hFF, 1'b1);
		rdr(ADDR_STATUS);
		chk_w(rd & 32'h0000_0012, 32'h0000_0012);
		wt(SC);
	endtask
	task automatic t_brown;
		line_mv <= 1000;
		wt(4);
		chk_b(drive_enable, 1'b1);
		line_mv <= 700;
		wde(1'b0, BC + 20);
		chk_b(n inside {[BC - 2:BC + 6]}, 1'b1);
		line_mv <= 1000;
		wde(1'b1, 20);
		line_mv <= 700;
		wt(SC / 2);
		chk_b(drive_enable, 1'b1);
		wde(1'b0, SC + BC);
		chk_b(n inside {[SC / 2 + BC - 10:SC / 2 + BC + 6]}, 1'b1);
		line_mv <= 1000;
		wde(1'b1, 20);
		line_mv <= 3500;
		wt(4);
		chk_b(drive_enable, 1'b0);
		line_mv <= 2900;
		wt(6);
		chk_b(drive_enable, 1'b0);
		drain_v <= 50;
		line_mv <= 1000;
		wde(1'b1, 20);
		chk_b(drive_enable, 1'b1);
		rdr(ADDR_STATUS);
		chk_w(rd & 32'h0000_000C, 32'h0000_000C);
	endtask
	task automatic finish_test;
		if (error_cnt == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		t_regs();
		t_start();
		t_fault();
		t_ovp();
		t_brown();
		finish_test();
	end
	initial
	begin
		#1_000_000;
		error_cnt++;
		finish_test();
	end
endmodule
bind sfseq_top sfseq_properties #(.FLT_CYC(FLT_CYC), .JIT_CYC(JIT_CYC))
	sfseq_properties_i (.*);
